// *** hw/binary_weighted_divider.sv ***
// Binary weighted divider: passes one ring tick in two to the power of the code
`timescale 1ns/100ps
module binary_weighted_divider (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ring_tick_i,
   input wire logic [3:0] divider_code_i,
   output logic clock_tick_o
);
   import clock_switch_pkg::*;

   logic [3:0] code_eff;
   logic [DIV_CNT_W-1:0] mask;
   logic [DIV_CNT_W-1:0] cnt_ff;

   // Codes above the maximum behave as the maximum (divide by 512)
   assign code_eff = (divider_code_i > DIVIDER_CODE_MAX) ? DIVIDER_CODE_MAX : divider_code_i;
   assign mask = DIV_CNT_W'((10'h001 << code_eff) - 10'h001);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
      end else if (ring_tick_i) begin
         cnt_ff <= ((cnt_ff & mask) == mask) ? '0 : cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_tick_o <= 1'b0;
      end else begin
         clock_tick_o <= ring_tick_i && ((cnt_ff & mask) == mask);
      end
   end
endmodule : binary_weighted_divider

// *** hw/clock_source_switch_and_dco.sv ***
// Clock source interlocks, clock monitor control and oscillator code control
`timescale 1ns/100ps
// Overview of operation
// - Select writes switch only with both enabled, target stable
// - Refused select writes leave selection unchanged
// - Internal disable waits for external selection
// - Monitor enable needs both clocks on, stable
// - Monitor interrupt enable needs monitor enabled
// - Flag clear begins with control read
// - Inactive selected source falls back when monitor enabled, other source active
// - Select bit shows source after fallback
// - Stage and divider codes set period
// - Divider is two to code, max 512
// - Divider code step doubles or halves period
// - Divider code moves only by carry, borrow
// - Ring length 17 to 31 by twos
// - Coarse step is stage code bit five
// - Period quantization error set by step size
// - Select set means external, clear internal
// - Reset forces internal clock selection
module clock_source_switch_and_dco (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Clock generator status
   input wire logic int_clock_stable_i,
   input wire logic ext_clock_stable_i,
   input wire logic int_clock_inactive_i,
   input wire logic ext_clock_inactive_i,
   // Loop filter steps and ring oscillator ticks
   input wire logic loop_filter_inc_i,
   input wire logic loop_filter_dec_i,
   input wire logic loop_filter_coarse_i,
   input wire logic ring_tick_i,
   // Outputs
   output logic int_clock_enable_o,
   output logic ext_clock_enable_o,
   output logic select_external_o,
   output logic monitor_irq_o,
   output logic internal_clock_tick_o,
   output logic [7:0] dco_stage_code_o,
   output logic [3:0] dco_divider_code_o,
   output logic [4:0] ring_len_o
);
   import clock_switch_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic int_enable_ff;
   logic ext_enable_ff;
   logic select_ff;
   logic mon_enable_ff;
   logic mon_irq_enable_ff;
   logic mon_flag_ff;
   logic flag_read_armed_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic irq_ff;
   logic [7:0] control_value;
   logic [31:0] dco_value;
   logic req;
   logic wr_ctrl;
   logic rd_ctrl;
   logic both_on;
   logic both_stable;
   logic sel_inactive;
   logic other_active;
   logic fallback;
   logic [7:0] wbyte;
   logic [7:0] stage_code;
   logic [3:0] divider_code;
   logic [4:0] ring_len;

   assign req = cyc_i && stb_i;
   // Writes and reads complete at the edge where the master sees ack
   assign wr_ctrl = req && ack_ff && we_i && (adr_i == ADDR_CONTROL) && sel_i[0];
   assign rd_ctrl = req && ack_ff && !we_i && (adr_i == ADDR_CONTROL);
   assign wbyte = dat_i[7:0];
   assign both_on = int_enable_ff && ext_enable_ff;
   assign both_stable = int_clock_stable_i && ext_clock_stable_i;

   // ------------------------------------------------------------
   // Clock monitor fallback
   // ------------------------------------------------------------
   assign sel_inactive = select_ff ? ext_clock_inactive_i : int_clock_inactive_i;
   assign other_active = select_ff ? !int_clock_inactive_i : !ext_clock_inactive_i;
   assign fallback = mon_enable_ff && sel_inactive && other_active;

   assign control_value = {mon_irq_enable_ff, mon_flag_ff, mon_enable_ff, select_ff,
                           int_enable_ff, int_clock_stable_i, ext_enable_ff,
                           ext_clock_stable_i};
   assign dco_value = {11'h000, ring_len, 4'h0, divider_code, stage_code};

   // ------------------------------------------------------------
   // Clock select
   // ------------------------------------------------------------
   // Interlocks use the enables as they stood before the write, so software
   // simply repeats the same write until every bit has settled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         select_ff <= 1'b0;
      end else if (fallback) begin
         select_ff <= !select_ff;
      end else if (wr_ctrl && (wbyte[BIT_CLOCK_SELECT] != select_ff)) begin
         if (both_on && (wbyte[BIT_CLOCK_SELECT] ? ext_clock_stable_i
                                                 : int_clock_stable_i)) begin
            select_ff <= wbyte[BIT_CLOCK_SELECT];
         end
      end
   end

   // ------------------------------------------------------------
   // Generator enables
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_enable_ff <= RST_INT_ENABLE;
      end else if (wr_ctrl) begin
         if (wbyte[BIT_INT_ENABLE]) begin
            int_enable_ff <= 1'b1;
         end else if (select_ff) begin
            int_enable_ff <= 1'b0;
         end
      end
   end

   // The selected source may not be turned off under the block's feet
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_enable_ff <= RST_EXT_ENABLE;
      end else if (wr_ctrl) begin
         if (wbyte[BIT_EXT_ENABLE]) begin
            ext_enable_ff <= 1'b1;
         end else if (!select_ff) begin
            ext_enable_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Monitor enables
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mon_enable_ff <= 1'b0;
      end else if (wr_ctrl) begin
         if (!wbyte[BIT_MON_ENABLE]) begin
            mon_enable_ff <= 1'b0;
         end else if (both_on && both_stable) begin
            mon_enable_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mon_irq_enable_ff <= 1'b0;
      end else if (wr_ctrl) begin
         if (!wbyte[BIT_MON_IRQ_ENABLE]) begin
            mon_irq_enable_ff <= 1'b0;
         end else if (mon_enable_ff) begin
            mon_irq_enable_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Monitor flag and its two-step clear
   // ------------------------------------------------------------
   // A read with the flag set arms the clear; the next control write completes it
   // if it writes zero to the flag bit. A bit-set or bit-clear of another bit on this register
   // writes the flag back as it was read, which is why it cannot lose the flag.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_read_armed_ff <= 1'b0;
      end else if (rd_ctrl && mon_flag_ff) begin
         flag_read_armed_ff <= 1'b1;
      end else if (wr_ctrl || !mon_flag_ff) begin
         flag_read_armed_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mon_flag_ff <= 1'b0;
      end else if (mon_enable_ff && (int_clock_inactive_i || ext_clock_inactive_i)) begin
         mon_flag_ff <= 1'b1; // Set wins over a clear in the same cycle
      end else if (wr_ctrl && flag_read_armed_ff && !wbyte[BIT_MON_FLAG]) begin
         mon_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= mon_flag_ff && mon_irq_enable_ff;
      end
   end

   // ------------------------------------------------------------
   // Wishbone answer: ack one cycle after the request, for one cycle
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req && !ack_ff;
      end
   end

   // Unmapped addresses read as zero and ignore writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (req && !ack_ff && !we_i) begin
         case (adr_i)
            ADDR_CONTROL: rdata_ff <= {24'h00_0000, control_value};
            ADDR_DCO_STATUS: rdata_ff <= dco_value;
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Oscillator codes and divider
   // ------------------------------------------------------------
   dco_code_stepper u_stepper (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .inc_i(loop_filter_inc_i),
      .dec_i(loop_filter_dec_i),
      .coarse_i(loop_filter_coarse_i),
      .stage_code_o(stage_code),
      .divider_code_o(divider_code),
      .ring_len_o(ring_len)
   );

   binary_weighted_divider u_divider (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ring_tick_i(ring_tick_i),
      .divider_code_i(divider_code),
      .clock_tick_o(internal_clock_tick_o)
   );

   assign ack_o = ack_ff;
   assign dat_o = rdata_ff;
   assign int_clock_enable_o = int_enable_ff;
   assign ext_clock_enable_o = ext_enable_ff;
   assign select_external_o = select_ff;
   assign monitor_irq_o = irq_ff;
   assign dco_stage_code_o = stage_code;
   assign dco_divider_code_o = divider_code;
   assign ring_len_o = ring_len;
endmodule : clock_source_switch_and_dco

// *** hw/dco_code_stepper.sv ***
// Loop filter step unit: stage code arithmetic with carry into the divider code
`timescale 1ns/100ps
module dco_code_stepper (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic inc_i,
   input wire logic dec_i,
   input wire logic coarse_i,
   output logic [7:0] stage_code_o,
   output logic [3:0] divider_code_o,
   output logic [4:0] ring_len_o
);
   import clock_switch_pkg::*;

   logic [8:0] step;
   logic [8:0] sum;
   logic [8:0] diff;

   assign step = coarse_i ? STEP_COARSE : STEP_FINE;
   assign sum = {1'b0, stage_code_o} + step;
   assign diff = {1'b0, stage_code_o} - step;

   // ------------------------------------------------------------
   // Stage and divider codes
   // ------------------------------------------------------------
   // The divider code is never stepped on its own, only through carry or borrow
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage_code_o <= RST_STAGE_CODE;
         divider_code_o <= RST_DIVIDER_CODE;
      end else if (inc_i && !dec_i) begin
         if (!sum[8]) begin
            stage_code_o <= sum[7:0];
         end else if (divider_code_o < DIVIDER_CODE_MAX) begin
            stage_code_o <= sum[7:0];
            divider_code_o <= divider_code_o + 4'h1;
         end else begin
            stage_code_o <= 8'hFF;
         end
      end else if (dec_i && !inc_i) begin
         if (!diff[8]) begin
            stage_code_o <= diff[7:0];
         end else if (divider_code_o != 4'h0) begin
            stage_code_o <= diff[7:0];
            divider_code_o <= divider_code_o - 4'h1;
         end else begin
            stage_code_o <= 8'h00;
         end
      end
   end

   // Ring length: 17 stage delays plus two per step of the top three bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ring_len_o <= RING_LEN_BASE + {1'b0, RST_STAGE_CODE[7:5], 1'b0};
      end else begin
         ring_len_o <= RING_LEN_BASE + {1'b0, stage_code_o[7:5], 1'b0};
      end
   end
endmodule : dco_code_stepper

// *** inc/clock_switch_pkg.sv ***
// Shared constants for the clock source switch and oscillator control block
package clock_switch_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_DCO_STATUS = 4'h4;
   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int BIT_EXT_STABLE = 0;
   localparam int BIT_EXT_ENABLE = 1;
   localparam int BIT_INT_STABLE = 2;
   localparam int BIT_INT_ENABLE = 3;
   localparam int BIT_CLOCK_SELECT = 4;
   localparam int BIT_MON_ENABLE = 5;
   localparam int BIT_MON_FLAG = 6;
   localparam int BIT_MON_IRQ_ENABLE = 7;
   localparam logic RST_INT_ENABLE = 1'b1;
   localparam logic RST_EXT_ENABLE = 1'b0;
   // ------------------------------------------------------------
   // Oscillator status register fields
   // ------------------------------------------------------------
   localparam int POS_STAGE = 0;
   localparam int POS_DIVIDER = 8;
   localparam int POS_RING_LEN = 16;
   localparam logic [7:0] RST_STAGE_CODE = 8'h80;
   localparam logic [3:0] RST_DIVIDER_CODE = 4'h0;
   localparam logic [3:0] DIVIDER_CODE_MAX = 4'h9;
   localparam logic [8:0] STEP_FINE = 9'h001;
   localparam logic [8:0] STEP_COARSE = 9'h020;
   localparam logic [4:0] RING_LEN_BASE = 5'h11;
   localparam int DIV_CNT_W = 9;
endpackage : clock_switch_pkg

// *** testbench/clock_switch_asserts.sv ***
// Assertions on the clock switch interlocks and oscillator codes
`timescale 1ns/100ps
module clock_switch_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic ack_o,
   input wire logic int_clock_stable_i,
   input wire logic ext_clock_stable_i,
   input wire logic int_clock_inactive_i,
   input wire logic ext_clock_inactive_i,
   input wire logic loop_filter_inc_i,
   input wire logic loop_filter_dec_i,
   input wire logic loop_filter_coarse_i,
   input wire logic int_clock_enable_o,
   input wire logic ext_clock_enable_o,
   input wire logic select_external_o,
   input wire logic monitor_irq_o,
   input wire logic [7:0] dco_stage_code_o,
   input wire logic [3:0] dco_divider_code_o,
   input wire logic [4:0] ring_len_o
);
   // ------
   // Properties
   // ------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic up;
   assign up = loop_filter_inc_i & ~loop_filter_dec_i & ~loop_filter_coarse_i;
   a_reset_internal: assert property (disable iff (1'b0)
      rst_i |=> !select_external_o && int_clock_enable_o) else $error("select after reset");
   a_switch_to_ext: assert property ($rose(select_external_o) && !$past(int_clock_inactive_i)
      |-> $past(int_clock_enable_o) && $past(ext_clock_enable_o) && $past(ext_clock_stable_i))
      else $error("external selected too early");
   a_switch_to_int: assert property ($fell(select_external_o) && !$past(ext_clock_inactive_i)
      |-> $past(int_clock_enable_o) && $past(ext_clock_enable_o) && $past(int_clock_stable_i))
      else $error("internal selected too early");
   a_int_off_order: assert property ($fell(int_clock_enable_o) |-> $past(select_external_o))
      else $error("internal disabled while selected");
   a_fallback_cause: assert property ($changed(select_external_o)
      && !($past(ack_o) && $past(we_i))
      |-> ($past(select_external_o) ? $past(ext_clock_inactive_i)
                                    : $past(int_clock_inactive_i)))
      else $error("select moved without cause");
   a_stage_fine: assert property (up && dco_stage_code_o != 8'hFF
      |=> dco_stage_code_o == $past(dco_stage_code_o) + 8'h01) else $error("stage step");
   a_carry_up: assert property (up && dco_stage_code_o == 8'hFF && dco_divider_code_o < 4'h9
      |=> dco_divider_code_o == $past(dco_divider_code_o) + 4'h1 && dco_stage_code_o == 8'h00)
      else $error("carry into divider");
   a_div_by_carry: assert property ($changed(dco_divider_code_o)
      |-> $past(loop_filter_inc_i ^ loop_filter_dec_i)) else $error("divider moved alone");
   a_ring_follows: assert property (!$past(rst_i)
      |-> ring_len_o == 5'h11 + {$past(dco_stage_code_o[7:5]), 1'b0}) else $error("ring length");
   c_to_ext: cover property ($rose(select_external_o));
   c_fallback: cover property ($fell(select_external_o) && !$past(ack_o));
   c_irq: cover property ($rose(monitor_irq_o));
   c_div: cover property ($changed(dco_divider_code_o));
endmodule : clock_switch_checker
bind clock_source_switch_and_dco clock_switch_checker clock_switch_checker_inst (.clk_i, .rst_i,
   .we_i, .ack_o, .int_clock_stable_i, .ext_clock_stable_i, .int_clock_inactive_i,
   .ext_clock_inactive_i, .loop_filter_inc_i, .loop_filter_dec_i, .loop_filter_coarse_i,
   .int_clock_enable_o, .ext_clock_enable_o, .select_external_o, .monitor_irq_o,
   .dco_stage_code_o, .dco_divider_code_o, .ring_len_o);

// *** testbench/tb.sv ***
// Self-checking bench for the clock switch and oscillator control block
`timescale 1ns/100ps
module tb;
   import clock_switch_pkg::*;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ring_tick_i, internal_clock_tick_o;
   logic int_clock_stable_i, ext_clock_stable_i, int_clock_inactive_i, ext_clock_inactive_i;
   logic loop_filter_inc_i, loop_filter_dec_i, loop_filter_coarse_i;
   logic int_clock_enable_o, ext_clock_enable_o, select_external_o, monitor_irq_o;
   logic [3:0] adr_i, sel_i, dco_divider_code_o;
   logic [31:0] dat_i, dat_o, rd;
   logic [7:0] dco_stage_code_o;
   logic [4:0] ring_len_o;
   int n_fail, num_checks;
   clock_source_switch_and_dco clock_source_switch_and_dco_inst (.clk_i, .rst_i, .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .int_clock_stable_i, .ext_clock_stable_i,
      .int_clock_inactive_i, .ext_clock_inactive_i, .loop_filter_inc_i, .loop_filter_dec_i,
      .loop_filter_coarse_i, .ring_tick_i, .int_clock_enable_o, .ext_clock_enable_o,
      .select_external_o, .monitor_irq_o, .internal_clock_tick_o, .dco_stage_code_o,
      .dco_divider_code_o, .ring_len_o);
   // ------
   // Tasks
   // ------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Holds the request until ack is seen; bounded so a dead slave cannot hang the run
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int k;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h000000, d};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 16);
      if (ack_o !== 1'b1) begin
         n_fail++;
         end_sim();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic rc(input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 8'h00);
      chk(rd, e);
   endtask : rc
   task automatic step(input logic i, input logic d, input logic c, input int n);
      repeat (n) begin
         loop_filter_inc_i <= i;
         loop_filter_dec_i <= d;
         loop_filter_coarse_i <= c;
         @(posedge clk_i);
         {loop_filter_inc_i, loop_filter_dec_i, loop_filter_coarse_i} <= 3'h0;
         @(posedge clk_i);
      end
   endtask : step
   // Ring ticks every other cycle; one count of slack for divider phase at code change
   task automatic ticks(input int c);
      int cnt;
      int e;
      cnt = 0;
      e = 2048 >> c;
      for (int i = 0; i < 4096; i++) begin
         ring_tick_i <= ~i[0];
         @(posedge clk_i);
         if (internal_clock_tick_o === 1'b1) cnt++;
      end
      chk({31'h0, cnt >= e - 1 && cnt <= e + 1}, 32'h1);
   endtask : ticks
   // ------
   // Sequence
   // ------
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      rst_i = 1'b1;
      sel_i = 4'hF;
      adr_i = 4'h0;
      dat_i = 32'h0;
      {cyc_i, stb_i, we_i, ring_tick_i, loop_filter_inc_i, loop_filter_dec_i} = 6'h0;
      {loop_filter_coarse_i, int_clock_stable_i, ext_clock_stable_i} = 3'h0;
      {int_clock_inactive_i, ext_clock_inactive_i} = 2'h0;
      n_fail = 0;
      num_checks = 0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, select_external_o}, 32'h0);
      rc(ADDR_CONTROL, 32'h08);
      rc(ADDR_DCO_STATUS, 32'h0019_0080);
      rc(4'h8, 32'h0);
      $display("test reset done");
      wb(1'b1, ADDR_CONTROL, 8'h1A);
      rc(ADDR_CONTROL, 32'h0A);
      wb(1'b1, ADDR_CONTROL, 8'h12);
      rc(ADDR_CONTROL, 32'h0A);
      wb(1'b1, ADDR_CONTROL, 8'hAA);
      rc(ADDR_CONTROL, 32'h0A);
      int_clock_stable_i <= 1'b1;
      ext_clock_stable_i <= 1'b1;
      wb(1'b1, ADDR_CONTROL, 8'h1A);
      chk({31'h0, select_external_o}, 32'h1);
      wb(1'b1, ADDR_CONTROL, 8'h12);
      int_clock_stable_i <= 1'b0;
      rc(ADDR_CONTROL, 32'h13);
      chk({30'h0, int_clock_enable_o, ext_clock_enable_o}, 32'h1);
      wb(1'b1, ADDR_CONTROL, 8'h1A);
      int_clock_stable_i <= 1'b1;
      rc(ADDR_CONTROL, 32'h1F);
      wb(1'b1, ADDR_CONTROL, 8'h18);
      rc(ADDR_CONTROL, 32'h1F);
      wb(1'b1, ADDR_CONTROL, 8'hBA);
      rc(ADDR_CONTROL, 32'h3F);
      wb(1'b1, ADDR_CONTROL, 8'hBA);
      rc(ADDR_CONTROL, 32'hBF);
      $display("test interlock done");
      ext_clock_inactive_i <= 1'b1;
      ext_clock_stable_i <= 1'b0;
      for (int k = 0; k < 8 && select_external_o !== 1'b0; k++) @(posedge clk_i);
      chk({31'h0, select_external_o}, 32'h0);
      repeat (2) @(posedge clk_i);
      chk({31'h0, monitor_irq_o}, 32'h1);
      ext_clock_inactive_i <= 1'b0;
      wb(1'b1, ADDR_CONTROL, 8'hAA);
      rc(ADDR_CONTROL, 32'hEE);
      wb(1'b1, ADDR_CONTROL, 8'hAA);
      rc(ADDR_CONTROL, 32'hAE);
      chk({31'h0, monitor_irq_o}, 32'h0);
      $display("test fallback done");
      step(1'b1, 1'b0, 1'b1, 4);
      rc(ADDR_DCO_STATUS, 32'h0011_0100);
      step(1'b0, 1'b1, 1'b0, 1);
      rc(ADDR_DCO_STATUS, 32'h001F_00FF);
      step(1'b1, 1'b0, 1'b0, 2);
      rc(ADDR_DCO_STATUS, 32'h0011_0101);
      step(1'b0, 1'b1, 1'b0, 2);
      rc(ADDR_DCO_STATUS, 32'h001F_00FF);
      step(1'b1, 1'b1, 1'b0, 1);
      wb(1'b1, ADDR_DCO_STATUS, 8'h00);
      rc(ADDR_DCO_STATUS, 32'h001F_00FF);
      for (int c = 0; c < 10; c++) begin
         ticks(c);
         step(1'b1, 1'b0, 1'b1, 8);
      end
      rc(ADDR_DCO_STATUS, 32'h001F_09FF);
      $display("test oscillator done");
      end_sim();
   end
endmodule : tb
